// ===== ssc_cfg.svh
// Purpose: Constants for the system status and control block.
// Assumes: Included by bare name; definitions only.
// Notes: Control register indices are kept; byte address is four times the index.
// Function
// RULE1: Bit seven flags repeated boot phase, read-only
// RULE2: Slow select bit halves internal oscillator rate
// RULE3: SRAM cleared; watchdog keeps page zero window
// RULE4: Software writes zero to reserved bits
// RULE5: Read-only copy of global interrupt enable
// RULE6: Watchdog flag set by hardware, cleared by zero
// RULE7: Power-on flag set by resets, cleared by zero
// RULE8: Watchdog disabled while power-on flag set
// RULE9: Sleep bit sleeps core until interrupt pending
// RULE10: Halt bit stops core; only resets clear it
// RULE11: Masked sources post but never become pending
// RULE12: Reset-cause flags survive the recorded resets
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// Register indices and byte addresses
`define SSC_IDX_CTRL_ONE 8'hFE
`define SSC_IDX_CTRL_ZERO 8'hFF
`define SSC_ADDR_CTRL_ONE ({2'h0, `SSC_IDX_CTRL_ONE, 2'h0})
`define SSC_ADDR_CTRL_ZERO ({2'h0, `SSC_IDX_CTRL_ZERO, 2'h0})
`define SSC_ADDR_IRQ_STATUS 12'h000
`define SSC_ADDR_IRQ_ENABLE 12'h004
`define SSC_ADDR_IRQ_CLEAR 12'h008
`define SSC_ADDR_W 12

// Control register one fields
`define SSC_BIT_REPEAT_BOOT 7
`define SSC_BIT_SLOW_OSC 4
`define SSC_BIT_RAM_INIT_DIS 0

// Control register zero fields
`define SSC_BIT_GIE_COPY 7
`define SSC_BIT_WDR_FLAG 5
`define SSC_BIT_POR_FLAG 4
`define SSC_BIT_SLEEP 3
`define SSC_BIT_HALT 0

// Interrupt status fields
`define SSC_IRQ_WDR 0
`define SSC_IRQ_EXTERNAL_PIN_RESET 1
`define SSC_IRQ_WAKE 2
`define SSC_IRQ_W 3

// Reset values
`define SSC_RST_POR_FLAG 1'h1
`define SSC_RST_BYTE 8'h00

// Oscillator rates selected by the slow bit, in MHz
`define SSC_OSC_FAST_MHZ 12
`define SSC_OSC_SLOW_MHZ 6

// SRAM geometry and the window a watchdog reset may keep
`define SSC_RAM_AW 10
`define SSC_RAM_LAST 10'h3FF
`define SSC_RAM_KEEP_LO 8'h03
`define SSC_RAM_KEEP_HI 8'hD7
`define SSC_RAM_FILL 8'h00

`endif

// ===== ssc_pkg.sv
// Purpose: Types shared by the system status and control block.
// Assumes: Constants come from ssc_cfg.svh.
// Notes: Nothing here is imported; users write ssc_pkg::name.
package ssc_pkg;

	// Boot sequencer: hold in reset, clear SRAM, run
	typedef enum logic [1:0] {
		SSC_BOOT_HOLD,
		SSC_BOOT_CLEAR,
		SSC_BOOT_RUN
	} ssc_boot_e;

	typedef logic [7:0] ssc_byte_t;

endpackage : ssc_pkg

// ===== ssc_ram_clear.sv
// Purpose: Walks the whole SRAM writing the fill value after a boot.
// Assumes: restart is a level from the sequencer on the same clock.
// Notes: Skipped cells still take one cycle, so clear time is fixed.
`timescale 1ns/10ps
`include "ssc_cfg.svh"
module ssc_ram_clear (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic restart,
	input wire logic preserve,
	output logic [`SSC_RAM_AW-1:0] ram_addr,
	output logic ram_we,
	output logic [7:0] ram_wdata,
	output logic done
);

	logic [`SSC_RAM_AW-1:0] addr_q, addr_d;
	logic [`SSC_RAM_AW-1:0] cell_q, cell_d;
	logic active_q, active_d;
	logic we_q, we_d;
	logic done_q, done_d;

	// Page zero cell inside the window kept across a watchdog reset
	function automatic logic in_keep(input logic [`SSC_RAM_AW-1:0] a);
		in_keep = (a[`SSC_RAM_AW-1:8] == '0) && (a[7:0] >= `SSC_RAM_KEEP_LO)
			&& (a[7:0] <= `SSC_RAM_KEEP_HI);
	endfunction : in_keep

	// Address walk; restart parks the engine at address zero
	always_comb
	begin
		addr_d = addr_q;
		cell_d = addr_q;
		active_d = active_q;
		we_d = 1'b0;
		done_d = 1'b0;
		if (restart)
		begin
			addr_d = '0;
			active_d = 1'b1;
		end
		else if (active_q)
		begin
			// RULE3 keep window
			we_d = !(preserve && in_keep(addr_q));
			if (addr_q == `SSC_RAM_LAST)
			begin
				active_d = 1'b0;
				done_d = 1'b1;
			end
			else
			begin
				addr_d = addr_q + 1'b1;
			end
		end
	end

	// Power-up starts a full clear at once
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_q <= '0;
			cell_q <= '0;
			active_q <= 1'b1;
			we_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			addr_q <= addr_d;
			cell_q <= cell_d;
			active_q <= active_d;
			we_q <= we_d;
			done_q <= done_d;
		end
	end

	// Strobe and its cell address are registered together, one cycle behind the walk
	assign ram_addr = cell_q;
	assign ram_we = we_q;
	assign ram_wdata = `SSC_RAM_FILL;
	assign done = done_q;

endmodule : ssc_ram_clear

// ===== ssc_top.sv
// Purpose: System status and control registers with reset-cause capture and boot sequencing.
// Assumes: hresetn is the power-on reset; pin and watchdog resets arrive as async levels.
// Notes: AHB-Lite slave with zero wait states; every access answers OKAY.
`timescale 1ns/10ps
`include "ssc_cfg.svh"
module ssc_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic external_pin_reset,
	input wire logic watchdog_reset,
	input wire logic global_irq_enable,
	input wire logic [7:0] irq_posted,
	input wire logic [7:0] irq_mask,
	output logic core_reset,
	output logic cpu_halt,
	output logic cpu_sleep,
	output logic slow_oscillator_select,
	output logic watchdog_enable,
	output logic [`SSC_RAM_AW-1:0] ram_addr,
	output logic ram_we,
	output logic [7:0] ram_wdata,
	output logic irq
);

	// Synchronisers for the two asynchronous reset sources
	logic [1:0] external_pin_reset_sync_q, external_pin_reset_sync_d;
	logic [1:0] wdr_sync_q, wdr_sync_d;
	logic external_pin_reset_lvl;
	logic wdr_lvl;

	// Bus pipeline
	logic wr_pend_q, wr_pend_d;
	logic [`SSC_ADDR_W-1:0] wr_addr_q, wr_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic hreadyout_q;
	logic hresp_q;
	logic acc_valid;

	// Register state
	logic repeated_boot_flag_q, repeated_boot_flag_d;
	logic slow_oscillator_select_q, slow_oscillator_select_d;
	logic ram_init_disable_q, ram_init_disable_d;
	logic watchdog_reset_flag_q, watchdog_reset_flag_d;
	logic power_on_reset_flag_q, power_on_reset_flag_d;
	logic sleep_q, sleep_d;
	logic halt_q, halt_d;
	logic [`SSC_IRQ_W-1:0] irq_status_q, irq_status_d;
	logic [`SSC_IRQ_W-1:0] irq_enable_q, irq_enable_d;
	logic [`SSC_IRQ_W-1:0] irq_set;
	logic irq_q, irq_d;
	logic watchdog_enable_q, watchdog_enable_d;
	logic irq_pending;

	// Boot sequencer
	ssc_pkg::ssc_boot_e boot_q, boot_d;
	logic cause_wdr_q, cause_wdr_d;
	logic core_reset_q, core_reset_d;
	logic clr_done;
	logic reset_req;

	// Address decode shared by the write and read paths
	function automatic logic hit(input logic [`SSC_ADDR_W-1:0] a, input logic [`SSC_ADDR_W-1:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	// Input synchronisers; only the second stage is read
	always_comb
	begin
		external_pin_reset_sync_d = {external_pin_reset_sync_q[0], external_pin_reset};
		wdr_sync_d = {wdr_sync_q[0], watchdog_reset};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			external_pin_reset_sync_q <= 2'h0;
			wdr_sync_q <= 2'h0;
		end
		else
		begin
			external_pin_reset_sync_q <= external_pin_reset_sync_d;
			wdr_sync_q <= wdr_sync_d;
		end
	end

	assign external_pin_reset_lvl = external_pin_reset_sync_q[1];
	assign wdr_lvl = wdr_sync_q[1];
	assign reset_req = external_pin_reset_lvl | wdr_lvl;

	// RULE11 pending gated by mask
	assign irq_pending = |(irq_posted & irq_mask);

	// Boot sequencing: hold while any reset source is active, then clear SRAM
	always_comb
	begin
		boot_d = boot_q;
		cause_wdr_d = cause_wdr_q;
		unique case (boot_q)
			ssc_pkg::SSC_BOOT_HOLD:
			begin
				if (!reset_req)
				begin
					boot_d = ssc_pkg::SSC_BOOT_CLEAR;
				end
			end
			ssc_pkg::SSC_BOOT_CLEAR:
			begin
				if (clr_done)
				begin
					boot_d = ssc_pkg::SSC_BOOT_RUN;
				end
			end
			ssc_pkg::SSC_BOOT_RUN:
			begin
			end
		endcase
		if (reset_req)
		begin
			boot_d = ssc_pkg::SSC_BOOT_HOLD;
			// A pin reset still active in the last reset cycle forces a full clear, even alongside a watchdog
			cause_wdr_d = wdr_lvl & ~external_pin_reset_lvl;
		end
		core_reset_d = (boot_d != ssc_pkg::SSC_BOOT_RUN);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			boot_q <= ssc_pkg::SSC_BOOT_CLEAR;
			cause_wdr_q <= 1'b0;
			core_reset_q <= 1'b1;
		end
		else
		begin
			boot_q <= boot_d;
			cause_wdr_q <= cause_wdr_d;
			core_reset_q <= core_reset_d;
		end
	end

	// SRAM clear engine, restarted for as long as the sequencer is in SSC_BOOT_HOLD
	ssc_ram_clear u_ram_clear (
		.hclk(hclk),
		.hresetn(hresetn),
		.restart(boot_q == ssc_pkg::SSC_BOOT_HOLD),
		// RULE3 watchdog keeps window
		.preserve(cause_wdr_q & ram_init_disable_q),
		.ram_addr(ram_addr),
		.ram_we(ram_we),
		.ram_wdata(ram_wdata),
		.done(clr_done)
	);

	// Register file and bus: writes land in the data phase, reads see the next state
	always_comb
	begin
		acc_valid = hsel & hready & htrans[1];
		wr_pend_d = acc_valid & hwrite;
		wr_addr_d = acc_valid ? haddr[`SSC_ADDR_W-1:0] : wr_addr_q;
		repeated_boot_flag_d = repeated_boot_flag_q;
		slow_oscillator_select_d = slow_oscillator_select_q;
		ram_init_disable_d = ram_init_disable_q;
		watchdog_reset_flag_d = watchdog_reset_flag_q;
		power_on_reset_flag_d = power_on_reset_flag_q;
		sleep_d = sleep_q;
		halt_d = halt_q;
		irq_enable_d = irq_enable_q;
		irq_status_d = irq_status_q;
		irq_set = '0;

		// Software writes; reserved bits are ignored and read back as zero
		if (wr_pend_q && hit(wr_addr_q, `SSC_ADDR_CTRL_ONE))
		begin
			// RULE2 slow oscillator select
			slow_oscillator_select_d = hwdata[`SSC_BIT_SLOW_OSC];
			ram_init_disable_d = hwdata[`SSC_BIT_RAM_INIT_DIS];
		end
		if (wr_pend_q && hit(wr_addr_q, `SSC_ADDR_CTRL_ZERO))
		begin
			// RULE6 zero clears only
			if (!hwdata[`SSC_BIT_WDR_FLAG])
			begin
				watchdog_reset_flag_d = 1'b0;
			end
			// RULE7 zero clears only
			if (!hwdata[`SSC_BIT_POR_FLAG])
			begin
				power_on_reset_flag_d = 1'b0;
			end
			// RULE9 sleep request
			if (hwdata[`SSC_BIT_SLEEP])
			begin
				sleep_d = 1'b1;
			end
			// RULE10 halt set only
			if (hwdata[`SSC_BIT_HALT])
			begin
				halt_d = 1'b1;
			end
		end
		if (wr_pend_q && hit(wr_addr_q, `SSC_ADDR_IRQ_ENABLE))
		begin
			irq_enable_d = hwdata[`SSC_IRQ_W-1:0];
		end
		if (wr_pend_q && hit(wr_addr_q, `SSC_ADDR_IRQ_CLEAR))
		begin
			irq_status_d = irq_status_q & ~hwdata[`SSC_IRQ_W-1:0];
		end

		// RULE9 wake on pending
		if (sleep_q && irq_pending)
		begin
			sleep_d = 1'b0;
			irq_set[`SSC_IRQ_WAKE] = 1'b1;
		end
		// A write that asks to sleep while a source is pending does not sleep
		if (irq_pending)
		begin
			sleep_d = 1'b0;
		end

		// Recorded resets: hardware sets after software clears in the same cycle
		if (wdr_lvl)
		begin
			// RULE6 hardware sets flag
			watchdog_reset_flag_d = 1'b1;
			irq_set[`SSC_IRQ_WDR] = 1'b1;
		end
		if (external_pin_reset_lvl)
		begin
			// RULE7 hardware sets flag
			power_on_reset_flag_d = 1'b1;
			irq_set[`SSC_IRQ_EXTERNAL_PIN_RESET] = 1'b1;
		end
		if (reset_req)
		begin
			// RULE10 resets clear halt
			halt_d = 1'b0;
			sleep_d = 1'b0;
			// RULE1 second boot seen
			repeated_boot_flag_d = 1'b1;
		end

		// Sticky status: a new event wins over a clear
		irq_status_d = irq_status_d | irq_set;
		irq_d = |(irq_status_d & irq_enable_d);
		// RULE8 watchdog gated by flag
		watchdog_enable_d = ~power_on_reset_flag_d;

		// Read capture from next-state values so a write is visible to the next read
		hrdata_d = 32'h0000_0000;
		if (acc_valid && !hwrite)
		begin
			if (hit(haddr[`SSC_ADDR_W-1:0], `SSC_ADDR_CTRL_ONE))
			begin
				// RULE1 read-only boot flag
				hrdata_d[`SSC_BIT_REPEAT_BOOT] = repeated_boot_flag_d;
				hrdata_d[`SSC_BIT_SLOW_OSC] = slow_oscillator_select_d;
				hrdata_d[`SSC_BIT_RAM_INIT_DIS] = ram_init_disable_d;
			end
			if (hit(haddr[`SSC_ADDR_W-1:0], `SSC_ADDR_CTRL_ZERO))
			begin
				// RULE5 interrupt enable copy
				hrdata_d[`SSC_BIT_GIE_COPY] = global_irq_enable;
				hrdata_d[`SSC_BIT_WDR_FLAG] = watchdog_reset_flag_d;
				hrdata_d[`SSC_BIT_POR_FLAG] = power_on_reset_flag_d;
				hrdata_d[`SSC_BIT_SLEEP] = sleep_d;
				hrdata_d[`SSC_BIT_HALT] = halt_d;
			end
			if (hit(haddr[`SSC_ADDR_W-1:0], `SSC_ADDR_IRQ_STATUS))
			begin
				hrdata_d[`SSC_IRQ_W-1:0] = irq_status_d;
			end
			if (hit(haddr[`SSC_ADDR_W-1:0], `SSC_ADDR_IRQ_ENABLE))
			begin
				hrdata_d[`SSC_IRQ_W-1:0] = irq_enable_d;
			end
		end
	end

	// RULE12 flags survive recorded resets
	// Of the resets only hresetn clears these, except the power-on flag which it sets; pin and watchdog resets merely set them
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			repeated_boot_flag_q <= 1'b0;
			slow_oscillator_select_q <= 1'b0;
			ram_init_disable_q <= 1'b0;
			watchdog_reset_flag_q <= 1'b0;
			power_on_reset_flag_q <= `SSC_RST_POR_FLAG;
			sleep_q <= 1'b0;
			halt_q <= 1'b0;
			irq_status_q <= '0;
			irq_enable_q <= '0;
			irq_q <= 1'b0;
			watchdog_enable_q <= 1'b0;
		end
		else
		begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q <= hrdata_d;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			repeated_boot_flag_q <= repeated_boot_flag_d;
			slow_oscillator_select_q <= slow_oscillator_select_d;
			ram_init_disable_q <= ram_init_disable_d;
			watchdog_reset_flag_q <= watchdog_reset_flag_d;
			power_on_reset_flag_q <= power_on_reset_flag_d;
			sleep_q <= sleep_d;
			halt_q <= halt_d;
			irq_status_q <= irq_status_d;
			irq_enable_q <= irq_enable_d;
			irq_q <= irq_d;
			watchdog_enable_q <= watchdog_enable_d;
		end
	end

	// Outputs, all straight from flip-flops
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign core_reset = core_reset_q;
	// RULE10 halt stops core
	assign cpu_halt = halt_q;
	assign cpu_sleep = sleep_q;
	// RULE2 oscillator rate select
	assign slow_oscillator_select = slow_oscillator_select_q;
	assign watchdog_enable = watchdog_enable_q;
	assign irq = irq_q;

endmodule : ssc_top

// ===== ssc_chk.sv
// Purpose: Port-level checker for the system status and control block.
// Assumes: Single hclk domain, hresetn asynchronous active low.
// Notes: Reset-cause flags are only visible over the bus, so they are checked by the bench.
`timescale 1ns/10ps
`include "ssc_cfg.svh"
module ssc_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic external_pin_reset,
	input wire logic watchdog_reset,
	input wire logic [7:0] irq_posted,
	input wire logic [7:0] irq_mask,
	input wire logic core_reset,
	input wire logic cpu_halt,
	input wire logic cpu_sleep,
	input wire logic watchdog_enable,
	input wire logic [`SSC_RAM_AW-1:0] ram_addr,
	input wire logic ram_we,
	input wire logic [7:0] ram_wdata
);
	// One domain, so clock and disable are stated once
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Zero wait states and always OKAY
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
	// Halt holds until a reset takes the core
	a_halt_hold: assert property (cpu_halt && !core_reset |=> cpu_halt || core_reset)
		else $error("halt dropped without reset");
	a_halt_reset: assert property (core_reset && $past(core_reset) |-> !cpu_halt && !cpu_sleep)
		else $error("halt or sleep kept through reset");
	// A long pin reset leaves the power-on flag set, so no watchdog
	a_wdog_off: assert property (external_pin_reset [*6] |-> !watchdog_enable)
		else $error("watchdog enabled after pin reset");
	a_pin_core: assert property ($rose(external_pin_reset) |-> ##[1:3] core_reset)
		else $error("pin reset not taken");
	a_wdr_core: assert property ($rose(watchdog_reset) |-> ##[1:3] core_reset)
		else $error("watchdog reset not taken");
	// Clearing writes zero, only inside a boot, in address order
	a_ram_fill: assert property (ram_we |-> ram_wdata == `SSC_RAM_FILL)
		else $error("ram fill not zero");
	a_ram_boot: assert property (ram_we |-> core_reset)
		else $error("ram written outside boot");
	a_ram_step: assert property (ram_we && $past(ram_we) |-> ram_addr == $past(ram_addr) + 1'b1)
		else $error("ram clear skipped a cell");
	// Sleep ends on a pending source, and only a pending source or reset ends it
	a_sleep_wake: assert property (cpu_sleep && (irq_posted & irq_mask) != 8'h00 |-> ##[1:3] !cpu_sleep)
		else $error("sleep not ended by pending source");
	a_sleep_cause: assert property ($fell(cpu_sleep) |->
		core_reset || $past(core_reset) || $past((irq_posted & irq_mask) != 8'h00))
		else $error("sleep ended without pending source");

	c_boot_done: cover property ($fell(core_reset));
	c_wake: cover property (cpu_sleep ##1 !cpu_sleep);
	c_halt: cover property ($rose(cpu_halt));
endmodule : ssc_chk

bind ssc_top ssc_chk ssc_chk_i (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
	.external_pin_reset(external_pin_reset), .watchdog_reset(watchdog_reset), .irq_posted(irq_posted),
	.irq_mask(irq_mask), .core_reset(core_reset), .cpu_halt(cpu_halt), .cpu_sleep(cpu_sleep),
	.watchdog_enable(watchdog_enable), .ram_addr(ram_addr), .ram_we(ram_we), .ram_wdata(ram_wdata));

// ===== testbench.sv
// Purpose: Directed bench for the system status and control block over AHB-Lite.
// Assumes: Zero wait states, but the bus tasks still wait on hready.
// Notes: Reset pulses are held 8 cycles so the two sync flops see them.
`timescale 1ns/10ps
`include "ssc_cfg.svh"
module testbench;
	localparam logic [31:0] A1 = 32'(`SSC_ADDR_CTRL_ONE);
	localparam logic [31:0] A0 = 32'(`SSC_ADDR_CTRL_ZERO);
	localparam logic [31:0] AST = 32'(`SSC_ADDR_IRQ_STATUS);
	localparam logic [31:0] AEN = 32'(`SSC_ADDR_IRQ_ENABLE);
	localparam logic [31:0] ACL = 32'(`SSC_ADDR_IRQ_CLEAR);
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, pin_rst = 1'b0, wd_rst = 1'b0, gie = 1'b0;
	logic [7:0] posted = 8'h00, mask = 8'h00, ram_wdata;
	logic core_reset, cpu_halt, cpu_sleep, slow, wd_en, ram_we, irq;
	logic [`SSC_RAM_AW-1:0] ram_addr;
	int miscompares = 0, compares = 0, we_count = 0, kept_hits = 0;

	assign hready = hreadyout;
	always #2.5 hclk = ~hclk;

	ssc_top ssc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .external_pin_reset(pin_rst), .watchdog_reset(wd_rst),
		.global_irq_enable(gie), .irq_posted(posted), .irq_mask(mask), .core_reset(core_reset),
		.cpu_halt(cpu_halt), .cpu_sleep(cpu_sleep), .slow_oscillator_select(slow),
		.watchdog_enable(wd_en), .ram_addr(ram_addr), .ram_we(ram_we), .ram_wdata(ram_wdata), .irq(irq));

	// Count clearing strobes and any that hit the page zero keep window
	always @(posedge hclk)
	begin
		if (ram_we === 1'b1)
		begin
			we_count++;
			if (ram_addr[9:8] == 2'h0 && ram_addr[7:0] >= 8'h03 && ram_addr[7:0] <= 8'hD7)
				kept_hits++;
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// One single transfer; entered and left just after a rising edge
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : xfer

	task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask : rdchk

	// Wait for the core to leave reset; a hang shows up as a mismatch
	task automatic wait_boot;
		int n;
		for (n = 0; n < 3000 && core_reset !== 1'b0; n++) @(posedge hclk);
		check("boot done", 0, core_reset);
	endtask : wait_boot

	// Pulse one reset source, then wait for the clear walk to finish
	task automatic pulse(input logic wdog, input int exp_we, input int exp_kept);
		we_count = 0;
		kept_hits = 0;
		wd_rst <= wdog;
		pin_rst <= !wdog;
		repeat (8) @(posedge hclk);
		wd_rst <= 1'b0;
		pin_rst <= 1'b0;
		wait_boot();
		check("clear strobes", exp_we, we_count);
		check("kept cells", exp_kept, kept_hits);
	endtask : pulse

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	initial
	begin
		#100us;
		miscompares++;
		conclude();
	end

	// Reserved bits are written as zero below, except the 32'hFF write to unmapped address 32'h100
	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk("ctrl0 reset", A0, 32'h10);
		rdchk("ctrl1 reset", A1, 32'h00);
		check("wdog off", 0, wd_en);
		wait_boot();
		check("boot strobes", 1024, we_count);
		gie <= 1'b1;
		xfer(1'b1, A0, 32'h00);
		xfer(1'b1, A0, 32'h30);
		rdchk("flags cleared", A0, 32'h80);
		check("wdog on", 1, wd_en);
		xfer(1'b1, A1, 32'h91);
		rdchk("ctrl1 rw", A1, 32'h11);
		check("slow osc", 1, slow);
		xfer(1'b1, A0, 32'h01);
		xfer(1'b1, A0, 32'h00);
		check("halt held", 1, cpu_halt);
		pulse(1'b1, 1024 - 213, 0);
		check("halt reset", 0, cpu_halt);
		rdchk("wdog flag", A0, 32'hA0);
		rdchk("boot repeat", A1, 32'h91);
		rdchk("irq status", AST, 32'h1);
		xfer(1'b1, AEN, 32'h1);
		repeat (2) @(posedge hclk);
		check("irq raised", 1, irq);
		xfer(1'b1, AEN, 32'h0);
		repeat (2) @(posedge hclk);
		check("irq masked", 0, irq);
		xfer(1'b1, AEN, 32'h1);
		xfer(1'b1, ACL, 32'h1);
		repeat (2) @(posedge hclk);
		check("irq cleared", 0, irq);
		xfer(1'b1, A0, 32'h00);
		rdchk("wdog flag clr", A0, 32'h80);
		posted <= 8'h04;
		xfer(1'b1, A0, 32'h08);
		repeat (5) @(posedge hclk);
		check("asleep masked", 1, cpu_sleep);
		mask <= 8'h04;
		repeat (4) @(posedge hclk);
		check("woken", 0, cpu_sleep);
		posted <= 8'h00;
		xfer(1'b1, 32'h100, 32'hFF);
		rdchk("unmapped", 32'h100, 32'h0);
		pulse(1'b0, 1024, 213);
		rdchk("pin flag", A0, 32'h90);
		rdchk("irq status pin", AST, 32'h6);
		rdchk("ctrl1 kept", A1, 32'h91);
		conclude();
	end
endmodule : testbench
